// *** spim_monitor.sv ***
// Serial switch input monitor with maskable change interrupt
`timescale 1ns/100ps
`include "spim_map.svh"

// Function
// - Sixteen switch ports are watched and their levels reported to host.
// - The serial shift register is sixteen bits wide.
// - Any unmasked port changing level raises the interrupt.
// - Ports selected by the mask never raise the interrupt.
// - Chip select falling captures all ports and clears the interrupt.
// - With chip select low, rising serial clock loads or shifts.
// - Serial input is sampled on each falling serial clock edge while chip select is low.
// - Chip select rising copies the shift register into the mask.
// - Enable high enables ports and interrupt; low disables, floats it.
// - Interrupt is open drain, active low.
// - Serial output is high impedance except while chip select is low and enable high.
// - Daisy chain: serial input passes to output, sixteen bits each.
module spim_monitor #(
  parameter int NUM_PORTS = `SPIM_NUM_PORTS,
  parameter logic MASK_POL = `SPIM_MASK_POL
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [NUM_PORTS-1:0] switch_port,
  input wire logic int_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic int_out,
  output logic int_oe_n
);
  import spim_pkg::*;

  localparam logic [NUM_PORTS-1:0] MASK_RST = `SPIM_MASK_RST;
  localparam logic [NUM_PORTS-1:0] LEVEL_RST = `SPIM_LEVEL_RST;
  localparam logic [NUM_PORTS-1:0] SHIFT_RST = `SPIM_SHIFT_RST;
  localparam int SETTLE = `SPIM_SNAP_SETTLE_CYC;

  if (NUM_PORTS != `SPIM_NUM_PORTS)
  begin : g_bad_width
    $error("spim_monitor: NUM_PORTS must equal the register width");
  end

  // Pin synchronisers: three stages, a change counts when the last two agree
  logic [NUM_PORTS-1:0] port_s1_q;
  logic [NUM_PORTS-1:0] port_s2_q;
  logic [NUM_PORTS-1:0] port_s3_q;
  spim_sync_t en_sync_q;
  spim_sync_t cs_sync_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port_s1_q <= LEVEL_RST;
      port_s2_q <= LEVEL_RST;
      port_s3_q <= LEVEL_RST;
    end
    else
    begin
      port_s1_q <= switch_port;
      port_s2_q <= port_s1_q;
      port_s3_q <= port_s2_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_sync_q <= 3'h0;
      cs_sync_q <= 3'h7;
    end
    else
    begin
      en_sync_q <= {en_sync_q[1:0], int_en};
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
    end
  end

  // Enable level and frame state, each filtered on two agreeing stages
  logic en_q;
  spim_frame_t frame_q;
  logic frame_open;
  logic frame_close;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      en_q <= 1'b0;
    else if (en_sync_q[1] == en_sync_q[2])
      en_q <= en_sync_q[2];
  end

  assign frame_open = (frame_q == SPIM_FRAME_IDLE) &&
    (cs_sync_q[2:1] == 2'b00);
  assign frame_close = (frame_q == SPIM_FRAME_ACTIVE) &&
    (cs_sync_q[2:1] == 2'b11);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_q <= SPIM_FRAME_IDLE;
    else
    begin
      case (frame_q)
        SPIM_FRAME_IDLE:
          if (frame_open)
            frame_q <= SPIM_FRAME_ACTIVE;
        SPIM_FRAME_ACTIVE:
          if (frame_close)
            frame_q <= SPIM_FRAME_IDLE;
        default:
          frame_q <= SPIM_FRAME_IDLE;
      endcase
    end
  end

  // Port levels; while disabled the ports are frozen and cause no events
  logic [NUM_PORTS-1:0] level_q;
  logic [NUM_PORTS-1:0] upd_w;
  logic [NUM_PORTS-1:0] chg_w;
  logic [NUM_PORTS-1:0] live_w;

  assign upd_w = en_q ? ~(port_s2_q ^ port_s3_q) : '0;
  assign chg_w = upd_w & (port_s3_q ^ level_q);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      level_q <= LEVEL_RST;
    else
      level_q <= (port_s3_q & upd_w) | (level_q & ~upd_w);
  end

  // Snapshot taken at frame start; it stays put for the whole frame
  logic [NUM_PORTS-1:0] snap_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      snap_q <= LEVEL_RST;
    else if (frame_open)
      snap_q <= level_q;
  end

  // Mask register, loaded from the shift register at frame end
  logic [NUM_PORTS-1:0] mask_q;
  logic [NUM_PORTS-1:0] shift_q;
  logic sin_q;
  logic [NUM_PORTS-1:0] frame_word;

  // Last sampled serial bit joins the word so all sixteen reach the mask
  assign frame_word = {shift_q[NUM_PORTS-2:0], sin_q};

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mask_q <= MASK_RST;
    else if (frame_close)
      mask_q <= frame_word;
  end

  assign live_w = MASK_POL ? ~mask_q : mask_q;

  // Pending interrupt: a new change wins over the clear at frame start
  logic pend_q;
  logic raise_w;

  assign raise_w = |(chg_w & live_w);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_q <= 1'b0;
    else if (raise_w)
      pend_q <= 1'b1;
    else if (frame_open)
      pend_q <= 1'b0;
  end

  // Open-drain interrupt: low only while pending and enabled
  logic int_oe_n_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      int_oe_n_q <= 1'b1;
    else
      int_oe_n_q <= ~(pend_q & en_q);
  end

  assign int_out = 1'b0;
  assign int_oe_n = int_oe_n_q;

  // Link side, on the serial clock. The snapshot and the shift register
  // cross as held words: each is stable while the other side reads it,
  // which needs the host to leave SETTLE core cycles after chip select
  // falls before its first rising edge.
  logic frame_rst;
  logic loaded_q;

  assign frame_rst = cs_n | sys_rst;

  always_ff @(posedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
      loaded_q <= 1'b0;
    else
      loaded_q <= 1'b1;
  end

  always_ff @(negedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      sin_q <= 1'b0;
    else if (!cs_n)
      sin_q <= serial_in;
  end

  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_q <= SHIFT_RST;
    else if (!cs_n)
    begin
      if (!loaded_q)
        shift_q <= snap_q;
      else
        shift_q <= {shift_q[NUM_PORTS-2:0], sin_q};
    end
  end

  assign serial_out = shift_q[NUM_PORTS-1];
  // Driven straight from the pins so the line releases with chip select
  assign serial_out_oe_n = cs_n | ~int_en;

  // Checks on the core clock
  logic [NUM_PORTS-1:0] word_seen;
  assign word_seen = frame_word;

  sequence s_frame_start;
    frame_open;
  endsequence

  sequence s_frame_end;
    frame_close;
  endsequence

  a_snap_capture: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_frame_start |=> snap_q == $past(level_q)
  ) else $error("snapshot not taken at frame start");

  a_int_clear: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_frame_start and !raise_w |=> !pend_q ##1 int_oe_n
  ) else $error("interrupt not cleared at frame start");

  a_int_raise: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    raise_w && en_q |=> pend_q ##1 !int_oe_n
  ) else $error("unmasked change did not raise interrupt");

  a_masked_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !pend_q && !raise_w |=> !pend_q
  ) else $error("interrupt rose without unmasked change");

  a_mask_blocks: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (chg_w & (MASK_POL ? ~mask_q : mask_q)) == '0 && !pend_q |=> !pend_q
  ) else $error("masked port raised interrupt");

  a_mask_load: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_frame_end |=> mask_q == $past(word_seen)
  ) else $error("mask not loaded at frame end");

  a_int_disabled: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !en_q [*2] |-> int_oe_n && int_out == 1'b0
  ) else $error("interrupt driven while disabled");

  a_level_filter: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    level_q != $past(level_q) |->
      $past(en_q) && ($past(port_s2_q) ~^ $past(port_s3_q)) != '0
  ) else $error("port level moved without two agreeing samples");

  a_out_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cs_n || !int_en |-> serial_out_oe_n
  ) else $error("serial output driven outside a frame");

  a_frame_pair: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_frame_start |=> !frame_open && frame_q == SPIM_FRAME_ACTIVE
  ) else $error("frame opened twice");

  // Checks on the serial clock
  a_first_load: assert property (
    @(posedge sclk) disable iff (frame_rst)
    !loaded_q |=> shift_q == $past(snap_q)
  ) else $error("first rising edge did not load snapshot");

  a_shift_step: assert property (
    @(posedge sclk) disable iff (frame_rst)
    loaded_q |=> shift_q == {$past(shift_q[NUM_PORTS-2:0]), $past(sin_q)}
  ) else $error("shift register did not advance");

  a_sample_in: assert property (
    @(negedge sclk) disable iff (frame_rst)
    1'b1 |=> sin_q == $past(serial_in)
  ) else $error("serial input not sampled on falling edge");

endmodule

// *** spim_map.svh ***
// Constants for the serial switch input monitor
`ifndef SPIM_MAP_SVH
`define SPIM_MAP_SVH

// Number of switch ports and width of the serial shift register
`define SPIM_NUM_PORTS 16

// Reset values
`define SPIM_MASK_RST 16'h0000
`define SPIM_LEVEL_RST 16'h0000
`define SPIM_SHIFT_RST 16'h0000

// Mask polarity: 1 means a set mask bit blocks that port
`define SPIM_MASK_POL 1'h1

// Timing of the host link, and its span in core clock cycles
`define SPIM_CORE_PERIOD_NS 20
`define SPIM_SCLK_MAX_MHZ 5
`define SPIM_SCLK_MIN_NS (1000 / `SPIM_SCLK_MAX_MHZ)
`define SPIM_SCLK_HALF_CYC \
  ((`SPIM_SCLK_MIN_NS / 2) / `SPIM_CORE_PERIOD_NS)

// Core cycles from chip select falling until the snapshot is stable
`define SPIM_SNAP_SETTLE_CYC 5

`endif

// *** spim_pkg.sv ***
// Types for the serial switch input monitor
package spim_pkg;

  typedef enum logic
  {
    SPIM_FRAME_IDLE,
    SPIM_FRAME_ACTIVE
  } spim_frame_t;

  typedef logic [2:0] spim_sync_t;

endpackage

// *** spim_host.sv ***
// Host model driving the serial link of the switch monitor
`timescale 1ns/100ps
module spim_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // Clock stands low outside frames; idle data sits at the pull-down level
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    cs_n = 1'b0;
    // Snapshot needs five core cycles before the first rise
    #120;
    // Link flops run on sclk alone; the rate only bounds setup
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = tx[i];
      #12 sclk = 1'b1;
      #24 sclk = 1'b0;
      // A released line reads inverted so a float never passes
      rx = {rx[30:0], serial_out_oe_n ? ~serial_out : serial_out};
      #12;
    end
    serial_in = 1'b0;
    #12 cs_n = 1'b1;
    #120;
  endtask
endmodule

// *** spim_monitor_bench.sv ***
// Self-checking testbench for the serial switch input monitor
`timescale 1ns/100ps
module spim_monitor_bench;
  logic core_clk, sys_rst, int_en, sclk, cs_n, serial_in;
  logic serial_out, serial_out_oe_n, int_out, int_oe_n;
  logic [15:0] switch_port;
  logic [31:0] rx;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  spim_monitor spim_monitor_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .switch_port(switch_port),
    .int_en(int_en),
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .int_out(int_out),
    .int_oe_n(int_oe_n)
  );

  spim_host spim_host_inst (
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs well under a tenth of this
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic t_reset();
    check("int_oe_n", int_oe_n, 1'b1);
    check("int_out", int_out, 1'b0);
    check("serial_out_oe_n", serial_out_oe_n, 1'b1);
  endtask

  task automatic t_read();
    switch_port = 16'ha5c3;
    step(10);
    check("int_oe_n", int_oe_n, 1'b0);
    spim_host_inst.xfer(16, 32'h0000_0000, rx);
    check("levels", rx[15:0], 16'ha5c3);
    check("serial_out_oe_n", serial_out_oe_n, 1'b1);
    step(8);
    check("int_oe_n", int_oe_n, 1'b1);
  endtask

  task automatic t_mask();
    spim_host_inst.xfer(16, 32'h0000_0001, rx);
    step(8);
    switch_port = switch_port ^ 16'h0001;
    step(10);
    check("int_oe_n", int_oe_n, 1'b1);
    switch_port = switch_port ^ 16'h0002;
    step(10);
    check("int_oe_n", int_oe_n, 1'b0);
    spim_host_inst.xfer(16, 32'h0000_0000, rx);
    check("levels", rx[15:0], 16'ha5c0);
    step(8);
    check("int_oe_n", int_oe_n, 1'b1);
  endtask

  task automatic t_daisy();
    spim_host_inst.xfer(32, 32'h1235_0000, rx);
    check("pass through", rx[15:0], 16'h1235);
    check("levels", rx[31:16], 16'ha5c0);
    step(8);
    switch_port = switch_port ^ 16'h0001;
    step(10);
    check("int_oe_n", int_oe_n, 1'b0);
  endtask

  task automatic t_enable();
    int_en = 1'b0;
    step(6);
    check("int_oe_n", int_oe_n, 1'b1);
    check("serial_out_oe_n", serial_out_oe_n, 1'b1);
    spim_host_inst.xfer(16, 32'h0000_0000, rx);
    check("released", rx[15:0], 16'h5a3e);
    step(1);
    switch_port = switch_port ^ 16'h0008;
    step(10);
    check("int_oe_n", int_oe_n, 1'b1);
    int_en = 1'b1;
    step(10);
    check("int_oe_n", int_oe_n, 1'b0);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    int_en = 1'b1;
    switch_port = 16'h0000;
    repeat (3) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    step(4);
    t_reset();
    t_read();
    t_mask();
    t_daisy();
    t_enable();
    wrap_up();
  end
endmodule
